/* File: hw/ipvmc_clkout.sv */
// Clock-output strength and division control
`timescale 1ns/1ps
module ipvmc_clkout (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] drive_sel_i,
    input  wire logic [1:0] divider_i,
    input  wire logic       osc_stop_i,
    output logic            gate_o,
    output logic [1:0]      drive_o,
    output logic            oe_o
);
    logic [1:0] phase_reg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // Pad passes reference edges only while gate is high
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            gate_o <= 1'b1;
        end else begin
            unique case (divider_i)
                ipvmc_pkg::DIV_FULL: gate_o <= 1'b1;
                ipvmc_pkg::DIV_3_4:  gate_o <= (phase_reg != 2'h3);
                ipvmc_pkg::DIV_1_2:  gate_o <= ~phase_reg[0];
                ipvmc_pkg::DIV_OFF:  gate_o <= 1'b1;
            endcase
        end
    end

    // Disabled output floats; the pad pull-up keeps it high
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            drive_o <= 2'h0;
            oe_o    <= 1'b1;
        end else begin
            drive_o <= drive_sel_i;
            oe_o    <= (drive_sel_i != ipvmc_pkg::DRV_OFF)
                    && (divider_i != ipvmc_pkg::DIV_OFF)
                    && !osc_stop_i;
        end
    end
endmodule // ipvmc_clkout

/* File: hw/ipvmc_config.sv */
// Plug-and-play vendor, logical-device and memory configuration registers
`timescale 1ns/1ps
module ipvmc_config #(
    parameter int INT_IO_SPAN_BITS = 5
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        cfg_config_state_i,
    input  wire logic        cfg_reset_cmd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic [7:0]       cfg_rdata_o,
    output logic             cfg_rvalid_o,
    output logic             serial_load_req_o,
    output logic [7:0]       serial_load_addr_o,
    input  wire logic [7:0]  serial_byte_i,
    input  wire logic        serial_byte_valid_i,
    input  wire logic [23:0] isa_addr_i,
    input  wire logic        isa_memr_n_i,
    input  wire logic        isa_ior_n_i,
    input  wire logic        cs_ready_i,
    input  wire logic [15:0] int_io_base_i,
    input  wire logic [15:0] cs_io_base_i,
    input  wire logic        cs_mem_hit_i,
    input  wire logic [15:0] int_rdata_i,
    output logic [15:0]      isa_data_o,
    output logic             isa_data_oe_o,
    output logic             iochrdy_o,
    output logic             iochrdy_oe_o,
    output logic             io_cs16_o,
    output logic             mem_cs16_o,
    output logic             extra_chip_select_n_o,
    input  wire logic        power_down_request_i,
    output logic             osc_stop_o,
    output logic             int_clk_off_o,
    output logic             clock_output_gate_o,
    output logic [1:0]       clock_out_drive_o,
    output logic             clock_output_oe_o
);
    logic [1:0]  bus_ctrl_reg;
    logic [5:0]  clk_ctrl_reg;
    logic [7:0]  mode_width_reg;
    logic        active_reg;
    logic [1:0]  range_chk_reg;
    logic [7:0]  base_hi_reg;
    logic [3:0]  base_lo_reg;
    logic        mem_size_reg;
    logic        mem_en_reg;
    logic        load_pend_reg;
    logic [23:0] addr_s1_reg;
    logic [23:0] addr_s2_reg;
    logic [2:0]  memr_n_reg;
    logic [2:0]  ior_n_reg;
    logic [1:0]  cs_rdy_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  rdata_next;
    logic        wr_ok;
    logic        defaults;
    logic        mem_start;
    logic        io_start;
    logic        int_mem_hit;
    logic        int_io_hit;
    logic        cs_io_hit;
    logic        cs_hit;
    logic        check_mode;
    logic [15:0] cs_mask;
    ipvmc_pkg::ipvmc_acc_t acc_reg;

    assign wr_ok    = cfg_wr_i && cfg_config_state_i;
    assign defaults = rst_i || cfg_reset_cmd_i;

    always_ff @(posedge clk_sys_i) begin
        if (defaults) begin
            bus_ctrl_reg  <= ipvmc_pkg::BUS_CTRL_RST;
            clk_ctrl_reg  <= ipvmc_pkg::CLK_CTRL_RST;
            active_reg    <= 1'b0;
            range_chk_reg <= 2'h0;
            base_hi_reg   <= ipvmc_pkg::BASE_HI_RST;
            base_lo_reg   <= ipvmc_pkg::BASE_LO_RST;
            mem_size_reg  <= 1'b0;
            mem_en_reg    <= 1'b0;
        end else if (wr_ok) begin
            unique case (cfg_addr_i)
                ipvmc_pkg::ADDR_BUS_CTRL:  bus_ctrl_reg  <= cfg_wdata_i[1:0];
                ipvmc_pkg::ADDR_CLK_CTRL:  clk_ctrl_reg  <= cfg_wdata_i[5:0];
                ipvmc_pkg::ADDR_ACTIVATE:
                    active_reg <= cfg_wdata_i[ipvmc_pkg::ACT_BIT];
                ipvmc_pkg::ADDR_RANGE_CHK: range_chk_reg <= cfg_wdata_i[1:0];
                ipvmc_pkg::ADDR_BASE_HI:   base_hi_reg   <= cfg_wdata_i;
                ipvmc_pkg::ADDR_BASE_LO:
                    base_lo_reg <= cfg_wdata_i[7:4];
                ipvmc_pkg::ADDR_MEM_CTRL:
                    mem_size_reg <= cfg_wdata_i[ipvmc_pkg::MC_SIZE_BIT];
                ipvmc_pkg::ADDR_LEN_LO:
                    mem_en_reg <= cfg_wdata_i[ipvmc_pkg::LEN_EN_BIT];
                default: ;
            endcase
        end
    end

    // Mode byte comes from the serial memory, not a fixed default
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_width_reg <= ipvmc_pkg::MODE_WIDTH_RST;
        end else if (serial_byte_valid_i && load_pend_reg) begin
            mode_width_reg <= serial_byte_i & ipvmc_pkg::MW_WRITE_MASK;
        end else if (wr_ok && cfg_addr_i == ipvmc_pkg::ADDR_MODE_WIDTH) begin
            mode_width_reg <= cfg_wdata_i & ipvmc_pkg::MW_WRITE_MASK;
        end
    end

    // A reset command arriving with the byte restarts the load
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            load_pend_reg <= 1'b1;
        end else if (cfg_reset_cmd_i) begin
            load_pend_reg <= 1'b1;
        end else if (serial_byte_valid_i) begin
            load_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            serial_load_req_o  <= 1'b0;
            serial_load_addr_o <= 8'h00;
        end else begin
            serial_load_req_o  <= load_pend_reg && !cfg_reset_cmd_i;
            serial_load_addr_o <= ipvmc_pkg::SERIAL_MODE_ADDR;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        unique case (cfg_addr_i)
            ipvmc_pkg::ADDR_BUS_CTRL:   rdata_next = {6'h00, bus_ctrl_reg};
            ipvmc_pkg::ADDR_CLK_CTRL:   rdata_next = {2'h0, clk_ctrl_reg};
            ipvmc_pkg::ADDR_MODE_WIDTH: rdata_next = mode_width_reg;
            ipvmc_pkg::ADDR_ACTIVATE:   rdata_next = {7'h00, active_reg};
            ipvmc_pkg::ADDR_RANGE_CHK:  rdata_next = {6'h00, range_chk_reg};
            ipvmc_pkg::ADDR_BASE_HI:    rdata_next = base_hi_reg;
            ipvmc_pkg::ADDR_BASE_LO:
                rdata_next = {base_lo_reg, 4'h0};
            ipvmc_pkg::ADDR_MEM_CTRL:
                rdata_next = {6'h00, mem_size_reg, 1'b0};
            ipvmc_pkg::ADDR_LEN_HI:
                rdata_next = {8{mem_en_reg}};
            ipvmc_pkg::ADDR_LEN_LO:
                rdata_next = {{4{mem_en_reg}}, 4'h0};
            default: rdata_next = 8'h00;
        endcase
    end

    // Reads outside the configuration state return zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_rdata_o  <= 8'h00;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rdata_o  <= cfg_config_state_i ? rdata_next : 8'h00;
            cfg_rvalid_o <= cfg_rd_i;
        end
    end

    // Bus pins are asynchronous to the reference clock
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_s1_reg <= 24'h000000;
            addr_s2_reg <= 24'h000000;
            memr_n_reg  <= 3'h7;
            ior_n_reg   <= 3'h7;
            cs_rdy_reg  <= 2'h3;
        end else begin
            addr_s1_reg <= isa_addr_i;
            addr_s2_reg <= addr_s1_reg;
            memr_n_reg  <= {memr_n_reg[1:0], isa_memr_n_i};
            ior_n_reg   <= {ior_n_reg[1:0], isa_ior_n_i};
            cs_rdy_reg  <= {cs_rdy_reg[0], cs_ready_i};
        end
    end

    assign cs_mask     = ipvmc_pkg::CS_MASK[mode_width_reg[2:0]];
    assign int_mem_hit = mode_width_reg[ipvmc_pkg::MW_INT_MEM_BIT]
                      && mem_en_reg
                      && addr_s2_reg[23:12] == {base_hi_reg, base_lo_reg};
    assign int_io_hit  = !mode_width_reg[ipvmc_pkg::MW_INT_MEM_BIT]
                      && addr_s2_reg[15:INT_IO_SPAN_BITS]
                         == int_io_base_i[15:INT_IO_SPAN_BITS];
    assign cs_io_hit   = (addr_s2_reg[15:0] & cs_mask)
                      == (cs_io_base_i & cs_mask);
    assign cs_hit      = mode_width_reg[ipvmc_pkg::MW_CS_MEM_BIT]
                      ? (cs_mem_hit_i && !memr_n_reg[1])
                      : (cs_io_hit && !ior_n_reg[1]);
    assign check_mode  = !active_reg && range_chk_reg[ipvmc_pkg::RC_EN_BIT];
    assign mem_start   = memr_n_reg[2] && !memr_n_reg[1] && int_mem_hit
                      && active_reg;
    assign io_start    = ior_n_reg[2] && !ior_n_reg[1] && int_io_hit
                      && (active_reg || check_mode);

    // I/O delay is counted from strobe start; conservative for back-to-back
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_reg <= ipvmc_pkg::ACC_IDLE;
            cnt_reg <= 4'h0;
        end else begin
            unique case (acc_reg)
                ipvmc_pkg::ACC_IDLE: begin
                    if (mem_start) begin
                        acc_reg <= ipvmc_pkg::ACC_WAIT;
                        cnt_reg <= ipvmc_pkg::MEM_DV_CYC;
                    end else if (io_start) begin
                        acc_reg <= ipvmc_pkg::ACC_WAIT;
                        cnt_reg <= ipvmc_pkg::IO_DV_CYC;
                    end
                end
                ipvmc_pkg::ACC_WAIT: begin
                    if (cnt_reg <= 4'h1) begin
                        acc_reg <= ipvmc_pkg::ACC_DATA;
                    end
                    cnt_reg <= cnt_reg - 4'h1;
                end
                ipvmc_pkg::ACC_DATA: begin
                    if (memr_n_reg[1] && ior_n_reg[1]) begin
                        acc_reg <= ipvmc_pkg::ACC_IDLE;
                    end
                end
                default: acc_reg <= ipvmc_pkg::ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            isa_data_o    <= 16'h0000;
            isa_data_oe_o <= 1'b0;
        end else begin
            isa_data_oe_o <= (acc_reg == ipvmc_pkg::ACC_WAIT && cnt_reg <= 4'h1)
                          || (acc_reg == ipvmc_pkg::ACC_DATA
                              && !(memr_n_reg[1] && ior_n_reg[1]));
            if (check_mode && !ior_n_reg[1]) begin
                isa_data_o <= {8'h00,
                    range_chk_reg[ipvmc_pkg::RC_RVL_BIT]
                    ? ipvmc_pkg::CHECK_VAL_ONE
                    : ipvmc_pkg::CHECK_VAL_ZERO};
            end else begin
                isa_data_o <= int_rdata_i;
            end
        end
    end

    // Ready: internal wait first, else pass the region's own ready
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            iochrdy_o    <= 1'b1;
            iochrdy_oe_o <= 1'b0;
        end else if (acc_reg == ipvmc_pkg::ACC_WAIT
                     && bus_ctrl_reg[ipvmc_pkg::BC_INT_READY_BIT]) begin
            iochrdy_o    <= 1'b0;
            iochrdy_oe_o <= 1'b1;
        end else if (cs_hit && active_reg
                     && bus_ctrl_reg[ipvmc_pkg::BC_CS_READY_BIT]) begin
            iochrdy_o    <= cs_rdy_reg[1];
            iochrdy_oe_o <= 1'b1;
        end else begin
            iochrdy_o    <= 1'b1;
            iochrdy_oe_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            extra_chip_select_n_o <= 1'b1;
            io_cs16_o             <= 1'b0;
            mem_cs16_o            <= 1'b0;
        end else begin
            extra_chip_select_n_o <= !(cs_hit && active_reg);
            io_cs16_o <= active_reg
                && ((int_io_hit && mode_width_reg[ipvmc_pkg::MW_INT_W_BIT])
                 || (cs_io_hit && !mode_width_reg[ipvmc_pkg::MW_CS_MEM_BIT]
                     && mode_width_reg[ipvmc_pkg::MW_CS_W_BIT]));
            mem_cs16_o <= active_reg && int_mem_hit && mem_size_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            osc_stop_o    <= 1'b0;
            int_clk_off_o <= 1'b0;
        end else begin
            osc_stop_o    <= power_down_request_i
                          && clk_ctrl_reg[ipvmc_pkg::CC_STP_BIT];
            int_clk_off_o <= power_down_request_i
                          && clk_ctrl_reg[ipvmc_pkg::CC_LOW_POWER_ENABLE_BIT];
        end
    end

    ipvmc_clkout u_clkout (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .drive_sel_i (clk_ctrl_reg[ipvmc_pkg::CC_DRV_LSB +: 2]),
        .divider_i   ({clk_ctrl_reg[ipvmc_pkg::CC_DIV1_BIT],
                       clk_ctrl_reg[ipvmc_pkg::CC_DIV0_BIT]}),
        .osc_stop_i  (osc_stop_o),
        .gate_o      (clock_output_gate_o),
        .drive_o     (clock_out_drive_o),
        .oe_o        (clock_output_oe_o)
    );
endmodule // ipvmc_config

/* File: hw/ipvmc_pkg.sv */
// Constants and types for the plug-and-play vendor and memory registers
package ipvmc_pkg;
    // Configuration register offsets on the address port
    localparam logic [7:0] ADDR_BUS_CTRL   = 8'h20;
    localparam logic [7:0] ADDR_CLK_CTRL   = 8'h21;
    localparam logic [7:0] ADDR_MODE_WIDTH = 8'h22;
    localparam logic [7:0] ADDR_ACTIVATE   = 8'h30;
    localparam logic [7:0] ADDR_RANGE_CHK  = 8'h31;
    localparam logic [7:0] ADDR_BASE_HI    = 8'h40;
    localparam logic [7:0] ADDR_BASE_LO    = 8'h41;
    localparam logic [7:0] ADDR_MEM_CTRL   = 8'h42;
    localparam logic [7:0] ADDR_LEN_HI     = 8'h43;
    localparam logic [7:0] ADDR_LEN_LO     = 8'h44;

    // Serial memory byte holding the mode and width defaults
    localparam logic [7:0] SERIAL_MODE_ADDR = 8'h07;

    // Bus control fields
    localparam int         BC_CS_READY_BIT  = 0;
    localparam int         BC_INT_READY_BIT = 1;
    localparam logic [1:0] BUS_CTRL_RST     = 2'h3;

    // Clock control fields; divider bits are stored swapped
    localparam int         CC_LOW_POWER_ENABLE_BIT   = 0;
    localparam int         CC_STP_BIT    = 1;
    localparam int         CC_DIV1_BIT   = 2;
    localparam int         CC_DIV0_BIT   = 3;
    localparam int         CC_DRV_LSB    = 4;
    localparam logic [5:0] CLK_CTRL_RST  = 6'h00;
    localparam logic [1:0] DRV_OFF       = 2'h3;
    localparam logic [1:0] DIV_FULL      = 2'h0;
    localparam logic [1:0] DIV_3_4       = 2'h1;
    localparam logic [1:0] DIV_1_2       = 2'h2;
    localparam logic [1:0] DIV_OFF       = 2'h3;

    // Mode and width fields
    localparam int         MW_INT_MEM_BIT = 7;
    localparam int         MW_CS_MEM_BIT  = 6;
    localparam int         MW_INT_W_BIT   = 5;
    localparam int         MW_CS_W_BIT    = 4;
    localparam logic [7:0] MW_WRITE_MASK  = 8'hF7;
    localparam logic [7:0] MODE_WIDTH_RST = 8'h00;

    // Logical device control fields
    localparam int         ACT_BIT        = 0;
    localparam int         RC_RVL_BIT     = 0;
    localparam int         RC_EN_BIT      = 1;
    localparam logic [7:0] CHECK_VAL_ONE  = 8'h55;
    localparam logic [7:0] CHECK_VAL_ZERO = 8'hAA;

    // Memory descriptor fields
    localparam int         MC_SIZE_BIT    = 1;
    localparam int         LEN_EN_BIT     = 4;
    localparam logic [7:0] BASE_HI_RST    = 8'h00;
    localparam logic [3:0] BASE_LO_RST    = 4'h0;

    // Chip-select I/O comparator masks over address bits 15..0
    localparam logic [15:0] CS_MASK [8] = '{
        16'hFFF8, 16'hFFE0, 16'hFFC0, 16'hFF80,
        16'hFF00, 16'hFC00, 16'hF000, 16'hE000
    };

    // Data-valid deadlines: half reference periods plus fixed delay
    localparam int         CLK_PS              = 25000;
    localparam int         DV_EXTRA_PS         = 20000;
    localparam int         MEM_DV_HALF_PERIODS = 5;
    localparam int         IO_DV_HALF_PERIODS  = 7;
    localparam int         MEM_DV_PS =
        MEM_DV_HALF_PERIODS * CLK_PS / 2 + DV_EXTRA_PS;
    localparam int         IO_DV_PS =
        IO_DV_HALF_PERIODS * CLK_PS / 2 + DV_EXTRA_PS;
    // Longest times round down
    localparam logic [3:0] MEM_DV_CYC = 4'(MEM_DV_PS / CLK_PS);
    localparam logic [3:0] IO_DV_CYC  = 4'(IO_DV_PS / CLK_PS);

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_DATA = 2'b10
    } ipvmc_acc_t;
endpackage

/* File: verification/ipvmc_config_asserts.sv */
// Concurrent checks on the configuration register, serial load and bus data ports
`timescale 1ns/1ps
module ipvmc_config_asserts (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       cfg_config_state_i,
    input  wire logic [7:0] cfg_addr_i,
    input  wire logic       cfg_rd_i,
    input  wire logic [7:0] cfg_rdata_o,
    input  wire logic       cfg_rvalid_o,
    input  wire logic       serial_load_req_o,
    input  wire logic [7:0] serial_load_addr_o,
    input  wire logic       serial_byte_valid_i,
    input  wire logic       cfg_reset_cmd_i,
    input  wire logic       isa_data_oe_o,
    input  wire logic       isa_ior_n_i,
    input  wire logic       isa_memr_n_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_rd(logic [7:0] a);
        cfg_rd_i && cfg_config_state_i && cfg_addr_i == a;
    endsequence
    sequence s_load_done;
        serial_load_req_o && serial_byte_valid_i && !cfg_reset_cmd_i;
    endsequence
    read_valid_a: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("read answer missing");
    no_spurious_valid_a: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
        else $error("read answer without request");
    vendor_zero_a: assert property (cfg_rd_i && cfg_addr_i >= 8'h23
        && cfg_addr_i <= 8'h2F |=> cfg_rdata_o == 8'h00)
        else $error("unimplemented location not zero");
    active_rsvd_a: assert property (s_rd(8'h30) |=> cfg_rdata_o[7:1] == 7'h00)
        else $error("activate reserved bits set");
    memctl_zero_a: assert property (s_rd(8'h42) |=>
        cfg_rdata_o[7:2] == 6'h00 && !cfg_rdata_o[0])
        else $error("memory control fixed bits wrong");
    length_copy_a: assert property (s_rd(8'h44) |=>
        cfg_rdata_o[3:0] == 4'h0 && cfg_rdata_o[7:5] == {3{cfg_rdata_o[4]}})
        else $error("length low copies wrong");
    base_low_a: assert property (s_rd(8'h41) |=> cfg_rdata_o[3:0] == 4'h0)
        else $error("base low bits not zero");
    unconfig_read_a: assert property (cfg_rd_i && !cfg_config_state_i
        |=> cfg_rdata_o == 8'h00)
        else $error("read outside configuration not zero");
    load_addr_a: assert property (serial_load_req_o |->
        serial_load_addr_o == 8'h07)
        else $error("serial load address wrong");
    load_end_a: assert property (s_load_done |-> ##[1:2] !serial_load_req_o)
        else $error("serial load request stuck");
    data_cause_a: assert property ($rose(isa_data_oe_o) |->
        !$past(isa_ior_n_i, 2) || !$past(isa_memr_n_i, 2))
        else $error("data driven without strobe");
endmodule // ipvmc_config_asserts
bind ipvmc_config ipvmc_config_asserts u_asserts (.*);

/* File: verification/ipvmc_serial_mem_model.sv */
// Byte-serial memory model answering the mode byte load
`timescale 1ns/1ps
module ipvmc_serial_mem_model #(
    parameter logic [7:0] MODE_BYTE = 8'hDB,
    parameter int         DELAY     = 6
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       load_req_i,
    output logic [7:0]      byte_o,
    output logic            byte_valid_o
);
    logic [7:0] cnt_reg;
    logic       done_reg;
    // Byte is only valid in the pulse; inverted afterwards to expose misuse
    always_ff @(posedge clk_sys_i) begin
        byte_valid_o <= 1'b0;
        if (rst_i) begin
            cnt_reg  <= 8'h00;
            done_reg <= 1'b0;
            byte_o   <= 8'h00;
        end else if (!load_req_i) begin
            cnt_reg  <= 8'h00;
            done_reg <= 1'b0;
            byte_o   <= ~byte_o;
        end else if (!done_reg && cnt_reg == 8'(DELAY)) begin
            byte_valid_o <= 1'b1;
            byte_o       <= MODE_BYTE;
            done_reg     <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            byte_o  <= ~byte_o;
        end
    end
endmodule // ipvmc_serial_mem_model

/* File: verification/tb_top.sv */
// Register and range check tests for the configuration block
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i = 0, rst_i = 1, cfg_state = 1, rst_cmd = 0, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, sbyte;
    logic rvalid, lreq, svalid, ior_n = 1, memr_n = 1, pdn = 0, data_oe;
    logic rdy, rdy_oe, io16, mem16, cs_n, gate;
    logic [23:0] isa_addr = 24'h000300;
    logic [15:0] isa_data;
    logic [1:0] drv;
    logic osc_stop, clk_off, ck_oe;
    int n_mismatch = 0, total_checks = 0, i;
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    ipvmc_config dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .cfg_config_state_i(cfg_state), .cfg_reset_cmd_i(rst_cmd),
        .cfg_addr_i(addr), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .serial_load_req_o(lreq),
        .serial_load_addr_o(), .serial_byte_i(sbyte),
        .serial_byte_valid_i(svalid), .isa_addr_i(isa_addr),
        .isa_memr_n_i(memr_n), .isa_ior_n_i(ior_n), .cs_ready_i(1'b1),
        .int_io_base_i(16'h0300), .cs_io_base_i(16'h0200), .cs_mem_hit_i(1'b0),
        .int_rdata_i(16'h1234), .isa_data_o(isa_data), .isa_data_oe_o(data_oe),
        .iochrdy_o(rdy), .iochrdy_oe_o(rdy_oe), .io_cs16_o(io16),
        .mem_cs16_o(mem16), .extra_chip_select_n_o(cs_n),
        .power_down_request_i(pdn),
        .osc_stop_o(osc_stop), .int_clk_off_o(clk_off),
        .clock_output_gate_o(gate), .clock_out_drive_o(drv),
        .clock_output_oe_o(ck_oe));
    ipvmc_serial_mem_model mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .load_req_i(lreq), .byte_o(sbyte), .byte_valid_o(svalid));
    task automatic check8(string nm, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic check16(string nm, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_load();
        for (int k = 0; k < 50; k++) begin
            @(posedge clk_sys_i);
            if (lreq === 1'b0) return;
        end
        n_mismatch++;
        final_report();
    endtask
    task automatic cfg_write(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a; wdata <= d; wr <= 1;
        @(posedge clk_sys_i);
        wr <= 0;
    endtask
    task automatic cfg_read(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_sys_i);
        addr <= a; rd <= 1;
        @(posedge clk_sys_i);
        rd <= 0;
        #1 check8("rvalid", 8'h01, {7'h00, rvalid});
        check8("rdata", exp, rdata);
    endtask
    // Address settles one edge before the strobe, as on the real bus
    task automatic bus_read(logic mem, logic [23:0] a, logic [15:0] exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk_sys_i);
        isa_addr <= a;
        @(posedge clk_sys_i);
        if (mem) memr_n <= 0;
        else ior_n <= 0;
        for (i = 0; i < 20 && data_oe !== 1'b1; i++) begin
            @(posedge clk_sys_i);
            if (rdy_oe === 1'b1 && rdy === 1'b0) seen = 1'b1;
        end
        if (i == 20) begin
            n_mismatch++;
            final_report();
        end else begin
            #1 check16("bus data", exp, isa_data);
            check8("ready wait", 8'h01, {7'h00, seen});
            check8("mem wide", {7'h00, mem}, {7'h00, mem16});
        end
        @(posedge clk_sys_i);
        memr_n <= 1;
        ior_n <= 1;
        repeat (6) @(posedge clk_sys_i);
    endtask
    task automatic clk_check(logic [7:0] v, logic [7:0] exp, logic [7:0] ng);
        logic [7:0] g;
        g = 8'h00;
        cfg_write(8'h21, v);
        repeat (4) @(posedge clk_sys_i);
        #1 check8("clock out", exp, {2'h0, drv, ck_oe, osc_stop, clk_off, 1'b0});
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_i);
            g = g + {7'h00, gate};
        end
        check8("gate count", ng, g);
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        wait_load();
        cfg_read(8'h20, 8'h03);
        cfg_read(8'h21, 8'h00);
        cfg_read(8'h22, 8'hD3);
        cfg_read(8'h30, 8'h00);
        cfg_read(8'h31, 8'h00);
        cfg_read(8'h42, 8'h00);
        cfg_read(8'h43, 8'h00);
        cfg_read(8'h44, 8'h00);
        for (int a = 8'h23; a <= 8'h3F; a++) // Skip implemented 0x30-31
            if (a != 8'h30 && a != 8'h31) cfg_read(8'(a), 8'h00);
        cfg_write(8'h30, 8'hFF); cfg_read(8'h30, 8'h01);
        cfg_write(8'h31, 8'hFF); cfg_read(8'h31, 8'h03);
        cfg_write(8'h40, 8'hA5); cfg_read(8'h40, 8'hA5);
        cfg_write(8'h41, 8'hFF); cfg_read(8'h41, 8'hF0);
        cfg_write(8'h42, 8'hFF); cfg_read(8'h42, 8'h02);
        cfg_write(8'h44, 8'hFF); cfg_read(8'h43, 8'hFF);
        cfg_read(8'h44, 8'hF0);
        bus_read(1'b1, 24'hA5F010, 16'h1234);
        cfg_write(8'h44, 8'hEF); cfg_read(8'h43, 8'h00);
        cfg_write(8'h21, 8'hFF); cfg_read(8'h21, 8'h3F);
        cfg_state <= 0;
        cfg_write(8'h30, 8'h00); cfg_read(8'h30, 8'h00);
        cfg_state <= 1;
        cfg_read(8'h30, 8'h01);
        cfg_write(8'h30, 8'h00);
        cfg_write(8'h22, 8'h18); cfg_read(8'h22, 8'h10);
        bus_read(1'b0, 24'h000300, 16'h0055);
        cfg_write(8'h31, 8'h02);
        bus_read(1'b0, 24'h000300, 16'h00AA);
        cfg_write(8'h30, 8'h01);
        @(posedge clk_sys_i);
        isa_addr <= 24'h000204;
        ior_n <= 0;
        repeat (4) @(posedge clk_sys_i);
        #1 check8("cs select", 8'h00, {7'h00, cs_n});
        check8("cs ready", 8'h03, {6'h00, rdy_oe, rdy});
        check8("cs wide", 8'h01, {7'h00, io16});
        @(posedge clk_sys_i);
        ior_n <= 1;
        pdn <= 1;
        for (int d = 0; d < 3; d++)
            clk_check(8'(d << 4), 8'(d << 4) | 8'h08, 8'h04);
        clk_check(8'h30, 8'h30, 8'h04);
        // Stopped oscillator also takes the clock output off the pad
        clk_check(8'h03, 8'h06, 8'h04);
        clk_check(8'h01, 8'h0A, 8'h04);
        clk_check(8'h04, 8'h08, 8'h02);
        clk_check(8'h08, 8'h08, 8'h03);
        clk_check(8'h0C, 8'h00, 8'h04);
        @(posedge clk_sys_i);
        rst_cmd <= 1;
        @(posedge clk_sys_i);
        rst_cmd <= 0;
        repeat (2) @(posedge clk_sys_i);
        wait_load();
        cfg_read(8'h31, 8'h00);
        cfg_read(8'h22, 8'hD3);
        final_report();
    end
endmodule // tb_top
